// [gpup_defines.svh]
// gpup_defines.svh
// register offsets, reset values and widths of the upper pin bank port
// assumes byte addresses on an apb bus with one aligned word per register
`ifndef GPUP_DEFINES_SVH
`define GPUP_DEFINES_SVH

`define GPUP_ADDR_W 8
`define GPUP_PINS 32
`define GPUP_LOW_FIELDS 16

`define GPUP_OFF_VALUE 8'h00
`define GPUP_OFF_ENABLE 8'h04
`define GPUP_OFF_OPEN_DRAIN 8'h08
`define GPUP_OFF_INPUT 8'h0C
`define GPUP_OFF_OSRC_LOW 8'h10
`define GPUP_OFF_OSRC_HIGH 8'h14
`define GPUP_OFF_TSRC_LOW 8'h18
`define GPUP_OFF_TSRC_HIGH 8'h1C
`define GPUP_OFF_VALUE_SET 8'h20
`define GPUP_OFF_VALUE_CLR 8'h24
`define GPUP_OFF_ENABLE_SET 8'h28
`define GPUP_OFF_ENABLE_CLR 8'h2C
`define GPUP_OFF_DRIVE_OE 8'h30
`define GPUP_OFF_DRIVE_OUT 8'h34

`define GPUP_RST_WORD 32'h0000_0000
`define GPUP_SYNC_STAGES 2

`endif

// [gpup_pkg.sv]
// gpup_pkg.sv
// types shared by the upper pin bank port and its pin multiplexer
// assumes nothing beyond a systemverilog compiler
package gpup_pkg;

   // two-bit source selector codes of each pin
   typedef enum logic [1:0] {
      gpup_src_own = 2'h0,
      gpup_src_alt_one = 2'h1,
      gpup_src_alt_two = 2'h2,
      gpup_src_alt_three = 2'h3
   } gpup_src_type;

   typedef logic [31:0] gpup_word_type;

endpackage : gpup_pkg

// [gpup_pin_if.sv]
// gpup_pin_if.sv
// configuration carried from the register file to the pin multiplexer
// assumes both ends run on pclk
interface gpup_pin_if;
   gpup_pkg::gpup_word_type value;
   gpup_pkg::gpup_word_type enable;
   gpup_pkg::gpup_word_type open_drain;
   gpup_pkg::gpup_word_type osrc_low;
   gpup_pkg::gpup_word_type osrc_high;
   gpup_pkg::gpup_word_type tsrc_low;
   gpup_pkg::gpup_word_type tsrc_high;

   modport regs (
      output value,
      output enable,
      output open_drain,
      output osrc_low,
      output osrc_high,
      output tsrc_low,
      output tsrc_high
   );

   modport mux (
      input value,
      input enable,
      input open_drain,
      input osrc_low,
      input osrc_high,
      input tsrc_low,
      input tsrc_high
   );
endinterface : gpup_pin_if

// [gpup_pin_mux.sv]
// gpup_pin_mux.sv
// per-pin source selection, open-drain handling and registered pad drive
// assumes configuration from the register file and alternate controllers on pclk
`include "gpup_defines.svh"

module gpup_pin_mux (
   input wire logic pclk,
   input wire logic presetn,
   gpup_pin_if.mux cfg,
   input wire logic [31:0] alt1_out,
   input wire logic [31:0] alt1_oe,
   input wire logic [31:0] alt2_out,
   input wire logic [31:0] alt2_oe,
   input wire logic [31:0] alt3_out,
   input wire logic [31:0] alt3_oe,
   output logic [31:0] pin_out,
   output logic [31:0] pin_oe
);

   // two-bit field of pin n from the low or high select word
   function automatic gpup_pkg::gpup_src_type field_of(
      input logic [31:0] lo,
      input logic [31:0] hi,
      input int n
   );
      logic [1:0] code;
      code = (n < `GPUP_LOW_FIELDS) ? lo[2*n +: 2] : hi[2*(n-`GPUP_LOW_FIELDS) +: 2];
      return gpup_pkg::gpup_src_type'(code);
   endfunction

   // choose own register bit or one of three alternate controllers
   function automatic logic pick(
      input gpup_pkg::gpup_src_type code,
      input logic own,
      input logic a1,
      input logic a2,
      input logic a3
   );
      logic res;
      res = own;
      unique case (code)
         gpup_pkg::gpup_src_own: res = own;
         gpup_pkg::gpup_src_alt_one: res = a1;
         gpup_pkg::gpup_src_alt_two: res = a2;
         gpup_pkg::gpup_src_alt_three: res = a3;
      endcase
      return res;
   endfunction

   logic [31:0] next_pin_out;
   logic [31:0] next_pin_oe;

   // per-pin selection and drive shaping
   for (genvar n = 0; n < `GPUP_PINS; n++) begin : g_pin
      gpup_pkg::gpup_src_type osel;
      gpup_pkg::gpup_src_type tsel;
      logic src_val;
      logic src_en;
      assign osel = field_of(cfg.osrc_low, cfg.osrc_high, n);
      assign tsel = field_of(cfg.tsrc_low, cfg.tsrc_high, n);
      assign src_val = pick(osel, cfg.value[n], alt1_out[n], alt2_out[n], alt3_out[n]);
      assign src_en = pick(tsel, cfg.enable[n], alt1_oe[n], alt2_oe[n], alt3_oe[n]);
      assign next_pin_out[n] = src_val & ~cfg.open_drain[n];
      assign next_pin_oe[n] = src_en & (~cfg.open_drain[n] | ~src_val);
   end

   // pad drive registered one edge behind the configuration
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pin_out <= `GPUP_RST_WORD;
         pin_oe <= `GPUP_RST_WORD;
      end else begin
         pin_out <= next_pin_out;
         pin_oe <= next_pin_oe;
      end
   end

endmodule // gpup_pin_mux

// [gpup_port.sv]
// gpup_port.sv
// upper pin bank port: apb register file, input synchronizer, pin multiplexer
// assumes an apb4 master on pclk, pads that resolve pin_out and pin_oe,
// and alternate controllers on pclk
//
// Operation
// - output source 00 selects own value register
// - three-state source 00 selects own enable register
// - open-drain bit 0 drives both levels
// - value 0 with enable 1 drives low
// - value 1 with enable 1 and open-drain 0 drives high
// - enable 0 floats the pin
// - input register returns sampled pin levels
// - pin 32+n is bit n; fields 2n
// - both sources 01 hand pin to alternate
`include "gpup_defines.svh"

module gpup_port (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [7:0] paddr,
   input wire logic [31:0] pwdata,
   input wire logic [3:0] pstrb,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire logic [31:0] pin_in,
   output logic [31:0] pin_out,
   output logic [31:0] pin_oe,
   output logic [31:0] pin_level,
   input wire logic [31:0] alt1_out,
   input wire logic [31:0] alt1_oe,
   input wire logic [31:0] alt2_out,
   input wire logic [31:0] alt2_oe,
   input wire logic [31:0] alt3_out,
   input wire logic [31:0] alt3_oe
);

   // merge write data into a word under the byte strobes
   function automatic logic [31:0] merge_bytes(
      input logic [31:0] old,
      input logic [31:0] wdata,
      input logic [3:0] strb
   );
      logic [31:0] res;
      res = old;
      for (int b = 0; b < 4; b++) begin
         if (strb[b]) begin
            res[8*b +: 8] = wdata[8*b +: 8];
         end
      end
      return res;
   endfunction

   // write data kept only in strobed bytes, as the bit mask for set and clear aliases
   function automatic logic [31:0] strobe_mask(
      input logic [31:0] wdata,
      input logic [3:0] strb
   );
      return merge_bytes(`GPUP_RST_WORD, wdata, strb);
   endfunction

   gpup_pin_if cfg_bus ();

   gpup_pkg::gpup_word_type pin_output_value;
   gpup_pkg::gpup_word_type pin_driver_enable;
   gpup_pkg::gpup_word_type pin_open_drain;
   gpup_pkg::gpup_word_type pin_input_level;
   gpup_pkg::gpup_word_type output_source_low;
   gpup_pkg::gpup_word_type output_source_high;
   gpup_pkg::gpup_word_type threestate_source_low;
   gpup_pkg::gpup_word_type threestate_source_high;
   gpup_pkg::gpup_word_type pin_meta;

   // map: 00 value, 04 driver enable, 08 open drain, 0C input level (read only),
   // 10/14 output source low/high, 18/1C three-state source low/high,
   // 20/24 value set/clear and 28/2C enable set/clear (write ones, read zero),
   // 30/34 registered pad enable and pad data readback (read only);
   // anything else, misaligned offsets included, answers with pslverr
   // address decode
   logic hit_value;
   logic hit_enable;
   logic hit_open_drain;
   logic hit_input;
   logic hit_osrc_low;
   logic hit_osrc_high;
   logic hit_tsrc_low;
   logic hit_tsrc_high;
   logic hit_value_set;
   logic hit_value_clr;
   logic hit_enable_set;
   logic hit_enable_clr;
   logic hit_drive_oe;
   logic hit_drive_out;
   logic addr_hit;
   assign hit_value = (paddr == `GPUP_OFF_VALUE);
   assign hit_enable = (paddr == `GPUP_OFF_ENABLE);
   assign hit_open_drain = (paddr == `GPUP_OFF_OPEN_DRAIN);
   assign hit_input = (paddr == `GPUP_OFF_INPUT);
   assign hit_osrc_low = (paddr == `GPUP_OFF_OSRC_LOW);
   assign hit_osrc_high = (paddr == `GPUP_OFF_OSRC_HIGH);
   assign hit_tsrc_low = (paddr == `GPUP_OFF_TSRC_LOW);
   assign hit_tsrc_high = (paddr == `GPUP_OFF_TSRC_HIGH);
   assign hit_value_set = (paddr == `GPUP_OFF_VALUE_SET);
   assign hit_value_clr = (paddr == `GPUP_OFF_VALUE_CLR);
   assign hit_enable_set = (paddr == `GPUP_OFF_ENABLE_SET);
   assign hit_enable_clr = (paddr == `GPUP_OFF_ENABLE_CLR);
   assign hit_drive_oe = (paddr == `GPUP_OFF_DRIVE_OE);
   assign hit_drive_out = (paddr == `GPUP_OFF_DRIVE_OUT);
   assign addr_hit = hit_value | hit_enable | hit_open_drain | hit_input
      | hit_osrc_low | hit_osrc_high | hit_tsrc_low | hit_tsrc_high
      | hit_value_set | hit_value_clr | hit_enable_set | hit_enable_clr
      | hit_drive_oe | hit_drive_out;

   // apb phases; the slave never inserts wait states
   logic setup_phase;
   logic access_phase;
   logic wr_fire;
   logic [31:0] wr_mask;
   assign setup_phase = psel & ~penable;
   assign access_phase = psel & penable;
   assign wr_fire = access_phase & pwrite & addr_hit;
   assign wr_mask = strobe_mask(pwdata, pstrb);
   assign pready = 1'b1;
   assign pslverr = access_phase & ~addr_hit;

   // per-register write enables; read-only offsets take no write
   logic wr_value;
   logic wr_enable;
   logic wr_open_drain;
   logic wr_osrc_low;
   logic wr_osrc_high;
   logic wr_tsrc_low;
   logic wr_tsrc_high;
   logic rd_capture;
   assign wr_value = wr_fire & (hit_value | hit_value_set | hit_value_clr);
   assign wr_enable = wr_fire & (hit_enable | hit_enable_set | hit_enable_clr);
   assign wr_open_drain = wr_fire & hit_open_drain;
   assign wr_osrc_low = wr_fire & hit_osrc_low;
   assign wr_osrc_high = wr_fire & hit_osrc_high;
   assign wr_tsrc_low = wr_fire & hit_tsrc_low;
   assign wr_tsrc_high = wr_fire & hit_tsrc_high;
   assign rd_capture = setup_phase & ~pwrite;

   // next values of the writable registers with set and clear aliases
   logic [31:0] next_value;
   logic [31:0] next_enable;
   assign next_value = hit_value ? merge_bytes(pin_output_value, pwdata, pstrb)
      : hit_value_set ? (pin_output_value | wr_mask)
      : hit_value_clr ? (pin_output_value & ~wr_mask)
      : pin_output_value;
   assign next_enable = hit_enable ? merge_bytes(pin_driver_enable, pwdata, pstrb)
      : hit_enable_set ? (pin_driver_enable | wr_mask)
      : hit_enable_clr ? (pin_driver_enable & ~wr_mask)
      : pin_driver_enable;

   // next values of the open-drain and select registers, byte-strobed
   logic [31:0] next_open_drain;
   logic [31:0] next_osrc_low;
   logic [31:0] next_osrc_high;
   logic [31:0] next_tsrc_low;
   logic [31:0] next_tsrc_high;
   assign next_open_drain = merge_bytes(pin_open_drain, pwdata, pstrb);
   assign next_osrc_low = merge_bytes(output_source_low, pwdata, pstrb);
   assign next_osrc_high = merge_bytes(output_source_high, pwdata, pstrb);
   assign next_tsrc_low = merge_bytes(threestate_source_low, pwdata, pstrb);
   assign next_tsrc_high = merge_bytes(threestate_source_high, pwdata, pstrb);

   // output value register with set and clear aliases
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pin_output_value <= `GPUP_RST_WORD;
      end else if (wr_value) begin
         pin_output_value <= next_value;
      end
   end

   // driver enable register with set and clear aliases
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pin_driver_enable <= `GPUP_RST_WORD;
      end else if (wr_enable) begin
         pin_driver_enable <= next_enable;
      end
   end

   // open-drain control register
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pin_open_drain <= `GPUP_RST_WORD;
      end else if (wr_open_drain) begin
         pin_open_drain <= next_open_drain;
      end
   end

   // output source selectors, pins 32..47 low word, 48..63 high word
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         output_source_low <= `GPUP_RST_WORD;
      end else if (wr_osrc_low) begin
         output_source_low <= next_osrc_low;
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         output_source_high <= `GPUP_RST_WORD;
      end else if (wr_osrc_high) begin
         output_source_high <= next_osrc_high;
      end
   end

   // three-state source selectors
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         threestate_source_low <= `GPUP_RST_WORD;
      end else if (wr_tsrc_low) begin
         threestate_source_low <= next_tsrc_low;
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         threestate_source_high <= `GPUP_RST_WORD;
      end else if (wr_tsrc_high) begin
         threestate_source_high <= next_tsrc_high;
      end
   end

   // first synchronizer stage on the asynchronous pads
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pin_meta <= `GPUP_RST_WORD;
      end else begin
         pin_meta <= pin_in;
      end
   end

   // second stage is the input register; only it reads the first stage
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pin_input_level <= `GPUP_RST_WORD;
      end else begin
         pin_input_level <= pin_meta;
      end
   end

   // synchronized levels also feed the alternate controllers
   assign pin_level = pin_input_level;

   // read data selection
   logic [31:0] rd_word;
   assign rd_word = hit_value ? pin_output_value
      : hit_enable ? pin_driver_enable
      : hit_open_drain ? pin_open_drain
      : hit_input ? pin_input_level
      : hit_osrc_low ? output_source_low
      : hit_osrc_high ? output_source_high
      : hit_tsrc_low ? threestate_source_low
      : hit_tsrc_high ? threestate_source_high
      : hit_drive_oe ? pin_oe
      : hit_drive_out ? pin_out
      : `GPUP_RST_WORD;

   // read data captured in the setup cycle, held through access
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         prdata <= `GPUP_RST_WORD;
      end else if (rd_capture) begin
         prdata <= rd_word;
      end
   end

   // configuration toward the pin multiplexer
   assign cfg_bus.value = pin_output_value;
   assign cfg_bus.enable = pin_driver_enable;
   assign cfg_bus.open_drain = pin_open_drain;
   assign cfg_bus.osrc_low = output_source_low;
   assign cfg_bus.osrc_high = output_source_high;
   assign cfg_bus.tsrc_low = threestate_source_low;
   assign cfg_bus.tsrc_high = threestate_source_high;

   // per-pin selection and registered pad drive
   gpup_pin_mux u_pin_mux (
      .pclk(pclk),
      .presetn(presetn),
      .cfg(cfg_bus.mux),
      .alt1_out(alt1_out),
      .alt1_oe(alt1_oe),
      .alt2_out(alt2_out),
      .alt2_oe(alt2_oe),
      .alt3_out(alt3_out),
      .alt3_oe(alt3_oe),
      .pin_out(pin_out),
      .pin_oe(pin_oe)
   );

endmodule // gpup_port

// [gpup_port_props.sv]
// gpup_port_props.sv
// concurrent checks on the ports of the upper pin bank port
// assumes one clock pclk and async active-low presetn
module gpup_port_props (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [7:0] paddr,
   input wire logic [31:0] pwdata,
   input wire logic [3:0] pstrb,
   input wire logic [31:0] prdata,
   input wire logic pready,
   input wire logic pslverr,
   input wire logic [31:0] pin_in,
   input wire logic [31:0] pin_out,
   input wire logic [31:0] pin_oe,
   input wire logic [31:0] pin_level,
   input wire logic [31:0] alt1_oe,
   input wire logic [31:0] alt2_oe,
   input wire logic [31:0] alt3_oe
);
   timeunit 1ns;
   timeprecision 1ns;
   logic [1:0] age;
   logic acc;
   logic no_alt;
   // access phase and quiet alternate enables
   assign acc = psel && penable;
   assign no_alt = ((alt1_oe | alt2_oe | alt3_oe) == 32'h0000_0000);
   // edges since reset release, saturating
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) age <= 2'h0;
      else if (age != 2'h3) age <= age + 2'h1;
   end
   default clocking @(posedge pclk); endclocking
   default disable iff (!presetn);
   ready_always_a: assert property (acc |-> pready)
      else $error("access without ready");
   misalign_err_a: assert property (acc && paddr[1:0] != 2'h0 |-> pslverr)
      else $error("misaligned access not refused");
   mapped_ok_a: assert property (acc && paddr[1:0] == 2'h0 && paddr <= 8'h34 |-> !pslverr)
      else $error("mapped access refused");
   err_data_a: assert property (acc && !pwrite && pslverr |-> prdata == 32'h0000_0000)
      else $error("refused read returned data");
   err_only_a: assert property (!acc |-> !pslverr)
      else $error("error outside access");
   input_sync_a: assert property (age >= 2'h2 |-> pin_level == $past(pin_in, 2))
      else $error("pin level not two edges behind pad");
   float_all_a: assert property (acc && pwrite && paddr == 8'h04 && pstrb == 4'hF
      && pwdata == 32'h0000_0000 && no_alt ##1 no_alt |=> pin_oe == 32'h0000_0000)
      else $error("pins driven after enable cleared");
   reset_idle_a: assert property (age == 2'h0 |-> pin_oe == 32'h0 && pin_out == 32'h0)
      else $error("pins driven after reset");
   cover property (acc && pwrite);
   cover property (acc && pslverr);
   cover property (age >= 2'h2 && pin_level != 32'h0000_0000);
endmodule // gpup_port_props

bind gpup_port gpup_port_props u_props (.pclk, .presetn, .psel, .penable, .pwrite,
   .paddr, .pwdata, .pstrb, .prdata, .pready, .pslverr, .pin_in, .pin_out, .pin_oe,
   .pin_level, .alt1_oe, .alt2_oe, .alt3_oe);

// [gpup_board.sv]
// gpup_board.sv
// board on the shared pins: pull-ups plus an optional board driver
// assumes pad data and enable from the port, pin 32+n on bit n,
// and trace logic that owns pins 49..63 until the host frees them
module gpup_board (
   input wire logic [31:0] pin_out,
   input wire logic [31:0] pin_oe,
   input wire logic [31:0] drv_val,
   input wire logic [31:0] drv_en,
   input wire logic trace_free,
   output logic [31:0] pin_in
);
   timeunit 1ns;
   timeprecision 1ns;
   logic [31:0] pad;
   // port drive wins, then board driver, else the pull-up
   assign pad = (pin_oe & pin_out) | (~pin_oe & ((drv_en & drv_val) | ~drv_en));
   // trace logic holds pins 49..63 low until the host frees them
   assign pin_in = trace_free ? pad : {15'h0, pad[16:0]};
endmodule // gpup_board

// [tb_gpio_port_upper_bank.sv]
// tb_gpio_port_upper_bank.sv
// directed apb bench for the upper pin bank port with a board model
// assumes the port answers with pready and no wait states
module tb_gpio_port_upper_bank;
   timeunit 1ns;
   timeprecision 1ns;
   localparam logic [31:0] V = 32'hA5C3_0F51;
   localparam logic [31:0] E = 32'hFFFF_0000;
   localparam logic [31:0] O = 32'h00FF_00FF;
   localparam logic [31:0] DV = 32'h3C3C_3C3C;
   localparam logic [31:0] DE = 32'h0F0F_F0F0;
   logic pclk, presetn, psel, penable, pwrite, pready, pslverr, re;
   logic [7:0] paddr;
   logic [3:0] pstrb;
   logic [31:0] pwdata, prdata, pin_in, pin_out, pin_oe, pin_level, rq;
   logic [31:0] alt1_out, alt1_oe, alt2_out, alt2_oe, alt3_out, alt3_oe;
   logic debug_trace_enable;
   logic [14:0] system_pin_function_ctl;
   logic [31:0] aoe [4] = '{32'h0, 32'h2, 32'h8000_0000, 32'h8000_0002};
   logic [7:0] offs [9] = '{8'h00, 8'h04, 8'h08, 8'h10, 8'h14, 8'h18, 8'h1C, 8'h30, 8'h34};
   int failures = 0;
   int compares = 0;
   int cyc = 0;
   gpup_port dut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .pstrb,
      .prdata, .pready, .pslverr, .pin_in, .pin_out, .pin_oe, .pin_level, .alt1_out,
      .alt1_oe, .alt2_out, .alt2_oe, .alt3_out, .alt3_oe);
   gpup_board board (.pin_out, .pin_oe, .drv_val(DV), .drv_en(DE),
      .trace_free(!debug_trace_enable && system_pin_function_ctl == 15'h7FFF), .pin_in);
   // clock and hang guard
   initial begin
      pclk = 1'b0;
      forever #50 pclk = ~pclk;
   end
   always @(posedge pclk) begin
      cyc++;
      if (cyc == 3000) begin
         failures++;
         test_done();
      end
   end
   task automatic test_done;
      $display("compares %0d failures %0d", compares, failures);
      if (failures == 0 && compares > 0)
         $display("Run complete: PASS");
      else
         $display("Run complete: FAIL");
      $finish;
   endtask
   // one apb transfer: setup, then access until pready
   task automatic apb(input logic [7:0] a, input logic w, input logic [31:0] d,
         input logic [3:0] s);
      @(posedge pclk);
      psel <= 1'b1;
      penable <= 1'b0;
      paddr <= a;
      pwrite <= w;
      pwdata <= d;
      pstrb <= s;
      @(posedge pclk);
      penable <= 1'b1;
      do @(posedge pclk); while (pready !== 1'b1);
      rq = prdata;
      re = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      apb(a, 1'b1, d, 4'hF);
   endtask
   task automatic chk(input string n, input logic [31:0] x, input logic [31:0] g);
      compares++;
      if (g !== x) begin
         failures++;
         $display("MISMATCH %s expected %h seen %h", n, x, g);
      end
   endtask
   task automatic rdc(input logic [7:0] a, input logic [31:0] x, input string n);
      apb(a, 1'b0, 32'h0, 4'h0);
      chk(n, x, rq);
   endtask
   task automatic settle;
      repeat (2) @(posedge pclk);
      #1;
   endtask
   // directed sequence
   initial begin
      {presetn, psel, penable, pwrite, paddr, pwdata, pstrb} = '0;
      {alt1_out, alt1_oe, alt2_out, alt2_oe, alt3_out, alt3_oe} = '0;
      debug_trace_enable = 1'b1;
      system_pin_function_ctl = 15'h0;
      repeat (4) @(posedge pclk);
      presetn <= 1'b1;
      debug_trace_enable <= 1'b0;
      system_pin_function_ctl <= 15'h7FFF;
      foreach (offs[i]) rdc(offs[i], 32'h0, "reset word");
      $display("test reset done");
      wr(8'h00, V);
      wr(8'h04, E);
      settle();
      chk("pin_out", V, pin_out);
      chk("pin_oe", E, pin_oe);
      repeat (2) @(posedge pclk);
      rdc(8'h0C, (V & E) | (~E & ((DE & DV) | ~DE)), "input");
      $display("test own drive done");
      wr(8'h08, O);
      wr(8'h04, 32'hFFFF_FFFF);
      settle();
      chk("od pin_out", V & ~O, pin_out);
      chk("od pin_oe", ~O | ~V, pin_oe);
      wr(8'h04, 32'h0);
      settle();
      chk("float pin_oe", 32'h0, pin_oe);
      $display("test open drain done");
      apb(8'h00, 1'b1, 32'hFFFF_FFFF, 4'h2);
      rdc(8'h00, V | 32'h0000_FF00, "strobe");
      wr(8'h20, 32'h0000_00A0);
      wr(8'h24, 32'h0100_0001);
      rdc(8'h00, 32'hA4C3_FFF0, "value set clear");
      rdc(8'h20, 32'h0, "set alias read");
      wr(8'h28, 32'h0000_F000);
      wr(8'h2C, 32'h0000_3000);
      rdc(8'h04, 32'h0000_C000, "enable set clear");
      rdc(8'h30, 32'h0000_C000, "pad enable readback");
      rdc(8'h34, 32'hA400_FF00, "pad data readback");
      wr(8'h2C, 32'hFFFF_FFFF);
      wr(8'h0C, 32'hFFFF_FFFF);
      chk("ro err", 32'h0, {31'h0, re});
      apb(8'h40, 1'b0, 32'h0, 4'hF);
      chk("unmapped err", 32'h1, {31'h0, re});
      chk("unmapped data", 32'h0, rq);
      apb(8'h01, 1'b1, 32'h0, 4'hF);
      chk("misaligned err", 32'h1, {31'h0, re});
      $display("test access done");
      wr(8'h00, 32'h0);
      wr(8'h08, 32'h0);
      alt1_out <= aoe[1];
      alt2_out <= aoe[2];
      alt3_out <= aoe[3];
      alt1_oe <= aoe[1];
      alt2_oe <= aoe[2];
      alt3_oe <= aoe[3];
      for (int c = 1; c < 4; c++) begin
         wr(8'h10, 32'(c) << 2);
         wr(8'h18, 32'(c) << 2);
         wr(8'h14, 32'(c) << 30);
         wr(8'h1C, 32'(c) << 30);
         settle();
         chk("alt pin_out", aoe[c], pin_out);
         chk("alt pin_oe", aoe[c], pin_oe);
      end
      $display("test alternate done");
      @(posedge pclk);
      presetn <= 1'b0;
      repeat (2) @(posedge pclk);
      presetn <= 1'b1;
      rdc(8'h10, 32'h0, "second reset");
      $display("test second reset done");
      test_done();
   end
endmodule // tb_gpio_port_upper_bank
